/* File: rtl/sfe_pkg.sv */
// Shared constants and carrier types of the serial flash front end.
package sfe_pkg;

  // System clock period and serial frame geometry.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BYTE_BITS     = 8;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  // Array organisation: page count, page sizes and erase spans in pages.
  localparam int unsigned PAGE_COUNT     = 4096;
  localparam int unsigned PAGE_AW        = 12;
  localparam int unsigned BUF_AW         = 9;
  localparam int unsigned PAGE_BYTES_BIN = 256;
  localparam int unsigned PAGE_BYTES_EXT = 264;
  localparam logic [12:0] SPAN_PAGE      = 13'h0001;
  localparam logic [12:0] SPAN_BLOCK     = 13'h0008;
  localparam logic [12:0] SPAN_SECTOR    = 13'h0100;
  localparam logic [12:0] SPAN_CHIP      = 13'h1000;

  // Kinds of self-timed array operation.
  typedef enum logic [2:0] {
    OPK_PROGRAM = 3'h0,
    OPK_PAGE_ER = 3'h1,
    OPK_BLK_ER  = 3'h2,
    OPK_SEC_ER  = 3'h3,
    OPK_CHIP_ER = 3'h4
  } sfe_op_kind_t;

  // Self-timed operation sequencer states; idle to run and run to done each change one bit.
  typedef enum logic [1:0] {
    OPS_IDLE = 2'b00,
    OPS_RUN  = 2'b01,
    OPS_DONE = 2'b11
  } sfe_op_state_t;

  // Serial pins as seen after synchronisation.
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic reset_n;
  } sfe_pins_t;

  // Write request into one of the two page buffers.
  typedef struct packed {
    logic              we;
    logic              sel;
    logic [BUF_AW-1:0] addr;
    logic [7:0]        data;
  } sfe_buf_wr_t;

  // Request to start a self-timed operation.
  typedef struct packed {
    logic                start;
    sfe_op_kind_t        kind;
    logic [PAGE_AW-1:0]  page;
  } sfe_op_req_t;

endpackage

/* File: rtl/sfe_front_end.sv */
// Serial front end of a page-organised flash: pins, page buffers, self-timed operations.
// Overview of operation
// - Chip select high deselects; device goes to standby, never deep power-down.
// - While deselected the serial output is released to high impedance.
// - While deselected, serial input bits are ignored.
// - Chip select falling edge opens a frame, rising edge closes it.
// - A self-timed operation finishes before standby is entered.
// - Input bits are sampled on rising serial clock edges.
// - Output bits change on falling serial clock edges.
// - Only SPI modes 0 and 3 are supported.
// - Program and erase durations are timed internally.
// - Array has a fixed page count; page size is binary or extended.
// - Two page buffers accept data while the array is busy.
// - Erase spans page, block, sector or whole chip.
// - First byte of a frame is the opcode, address bytes follow.
// - All bytes travel most significant bit first.
// - Reset pin low aborts operations and holds logic idle.
`timescale 1ns/1ps
`default_nettype none
module sfe_front_end
  import sfe_pkg::*;
#(
  parameter int unsigned T_PROG_NS   = 2000000,
  parameter int unsigned T_PAGE_ER_NS = 20000000,
  parameter int unsigned T_BLK_ER_NS  = 45000000,
  parameter int unsigned T_SEC_ER_NS  = 700000000,
  parameter int unsigned T_CHIP_ER_NS = 1000000000
)(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Device pins.
  input  wire logic               cs_n_pin,
  input  wire logic               sck_pin,
  input  wire logic               si_pin,
  input  wire logic               reset_n_pin,
  output logic                    so_o,
  output logic                    so_oe,
  // Received byte stream.
  output logic [7:0]              rx_byte,
  output logic                    rx_valid,
  output logic                    rx_is_opcode,
  output logic [15:0]             rx_index,
  output logic                    frame_start,
  output logic                    frame_end,
  output logic                    selected,
  // Transmit byte stream.
  input  wire logic [7:0]         tx_byte,
  output logic                    tx_take,
  // Page buffers.
  input  wire sfe_buf_wr_t        buf_wr,
  input  wire logic               buf_rd_sel,
  input  wire logic [BUF_AW-1:0]  buf_rd_addr,
  output logic [7:0]              buf_rdata,
  // Configuration and self-timed operations.
  input  wire logic               page_bin,
  output logic [8:0]              page_bytes,
  input  wire sfe_op_req_t        op_req,
  output logic                    op_busy,
  output logic                    op_done,
  output logic [PAGE_AW-1:0]      op_first_page,
  output logic [12:0]             op_span,
  output logic                    standby
);

  // Cycle counts of each self-timed operation, rounded up.
  localparam int unsigned C_PROG    = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_PAGE_ER = (T_PAGE_ER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_BLK_ER  = (T_BLK_ER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_SEC_ER  = (T_SEC_ER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_CHIP_ER = (T_CHIP_ER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [31:0] op_cycles(input sfe_op_kind_t k);
    unique case (k)
      OPK_PROGRAM: op_cycles = 32'(C_PROG);
      OPK_PAGE_ER: op_cycles = 32'(C_PAGE_ER);
      OPK_BLK_ER:  op_cycles = 32'(C_BLK_ER);
      OPK_SEC_ER:  op_cycles = 32'(C_SEC_ER);
      default:     op_cycles = 32'(C_CHIP_ER);
    endcase
  endfunction

  // Pages covered by an operation; the first page is aligned to the span.
  function automatic logic [12:0] op_pages(input sfe_op_kind_t k);
    unique case (k)
      OPK_PROGRAM, OPK_PAGE_ER: op_pages = SPAN_PAGE;
      OPK_BLK_ER:  op_pages = SPAN_BLOCK;
      OPK_SEC_ER:  op_pages = SPAN_SECTOR;
      default:     op_pages = SPAN_CHIP;
    endcase
  endfunction

  function automatic logic [8:0] page_limit(input logic bin);
    page_limit = bin ? 9'(PAGE_BYTES_BIN) : 9'(PAGE_BYTES_EXT);
  endfunction

  // Pin synchronisers: stage one feeds only stage two.
  sfe_pins_t pin_s1_q;
  sfe_pins_t pin_s2_q;
  sfe_pins_t pin_s3_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_s1_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, reset_n: 1'b1};
      pin_s2_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, reset_n: 1'b1};
      pin_s3_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, reset_n: 1'b1};
    end
    else
    begin
      pin_s1_q <= '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin, reset_n: reset_n_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic clr;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  logic sck_rise;
  logic sck_fall;

  assign clr      = rst | ~pin_s2_q.reset_n;
  assign cs_fall  = pin_s3_q.cs_n & ~pin_s2_q.cs_n;
  assign cs_rise  = ~pin_s3_q.cs_n & pin_s2_q.cs_n;
  assign sel      = ~pin_s2_q.cs_n & ~pin_s3_q.cs_n;
  assign sck_rise = sel & ~pin_s3_q.sck & pin_s2_q.sck;
  assign sck_fall = sel & pin_s3_q.sck & ~pin_s2_q.sck;

  // Receive shifter and counters.
  logic [2:0]  bit_q;
  logic [6:0]  rx_sh_q;
  logic [15:0] byte_q;

  always_ff @(posedge clk_sys)
  begin
    if (clr || cs_fall)
    begin
      bit_q   <= '0;
      byte_q  <= '0;
      rx_sh_q <= '0;
    end
    else if (sck_rise)
    begin
      bit_q   <= bit_q + 3'h1;
      rx_sh_q <= {rx_sh_q[5:0], pin_s2_q.si};
      if (bit_q == BIT_LAST)
        byte_q <= byte_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      rx_byte      <= '0;
      rx_valid     <= 1'b0;
      rx_is_opcode <= 1'b0;
      rx_index     <= '0;
    end
    else
    begin
      rx_valid <= sck_rise && (bit_q == BIT_LAST) && !cs_fall;
      if (sck_rise && (bit_q == BIT_LAST) && !cs_fall)
      begin
        rx_byte      <= {rx_sh_q, pin_s2_q.si};
        rx_is_opcode <= (byte_q == 16'h0000);
        rx_index     <= byte_q;
      end
    end
  end

  // Frame markers and selection level.
  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      selected    <= 1'b0;
    end
    else
    begin
      frame_start <= cs_fall;
      frame_end   <= cs_rise;
      selected    <= ~pin_s2_q.cs_n;
    end
  end

  // Transmit shifter: first bit is presented at frame start so mode 0 sees it
  // before the first rising edge; a mode 3 idle-high falling edge shifts nothing.
  logic [7:0] tx_sh_q;
  logic       rise_seen_q;
  logic       tx_load;

  assign tx_load = cs_fall | (sck_rise & (bit_q == BIT_LAST));

  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      tx_sh_q     <= '0;
      rise_seen_q <= 1'b0;
      so_o        <= 1'b0;
      so_oe       <= 1'b0;
      tx_take     <= 1'b0;
    end
    else
    begin
      tx_take <= tx_load;
      so_oe   <= ~pin_s2_q.cs_n;
      if (cs_fall)
      begin
        so_o        <= tx_byte[7];
        tx_sh_q     <= {tx_byte[6:0], 1'b0};
        rise_seen_q <= 1'b0;
      end
      else
      begin
        if (sck_rise)
          rise_seen_q <= 1'b1;
        if (sck_rise && (bit_q == BIT_LAST))
          tx_sh_q <= tx_byte;
        else if (sck_fall && rise_seen_q)
        begin
          so_o    <= tx_sh_q[7];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Two page buffers, writable at any time except while reset is held, including during array busy.
  logic [7:0] buf_mem [0:1][0:PAGE_BYTES_EXT-1];

  always_ff @(posedge clk_sys)
  begin
    if (buf_wr.we && !clr && (buf_wr.addr < page_limit(page_bin)))
      buf_mem[buf_wr.sel][buf_wr.addr] <= buf_wr.data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (clr)
      buf_rdata <= '0;
    else if (buf_rd_addr < page_limit(page_bin))
      buf_rdata <= buf_mem[buf_rd_sel][buf_rd_addr];
    else
      buf_rdata <= '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (clr)
      page_bytes <= 9'(PAGE_BYTES_EXT);
    else
      page_bytes <= page_limit(page_bin);
  end

  // Self-timed operation sequencer.
  sfe_op_state_t op_state_q;
  logic [31:0]   op_cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      op_state_q    <= OPS_IDLE;
      op_cnt_q      <= '0;
      op_first_page <= '0;
      op_span       <= '0;
    end
    else
    begin
      unique case (op_state_q)
        OPS_IDLE:
          if (op_req.start)
          begin
            op_state_q    <= OPS_RUN;
            op_cnt_q      <= op_cycles(op_req.kind) - 32'h1;
            op_span       <= op_pages(op_req.kind);
            op_first_page <= op_req.page & ~(PAGE_AW'(op_pages(op_req.kind)) - 12'h001);
          end
        OPS_RUN:
          if (op_cnt_q == 32'h0)
            op_state_q <= OPS_DONE;
          else
            op_cnt_q <= op_cnt_q - 32'h1;
        OPS_DONE:
          op_state_q <= OPS_IDLE;
        default:
          op_state_q <= OPS_IDLE;
      endcase
    end
  end

  assign op_busy = (op_state_q == OPS_RUN);
  assign op_done = (op_state_q == OPS_DONE);
  assign standby = pin_s2_q.cs_n & (op_state_q == OPS_IDLE);

endmodule
`default_nettype wire

/* File: bench/sfe_checker_assertions.sv */
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module sfe_checker
  import sfe_pkg::*;
(
  // Clock and resets.
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               reset_n_pin,
  // Watched ports.
  input wire logic               page_bin,
  input wire logic               so_oe,
  input wire logic               rx_valid,
  input wire logic               rx_is_opcode,
  input wire logic [15:0]        rx_index,
  input wire logic               frame_start,
  input wire logic               frame_end,
  input wire logic               selected,
  input wire logic [8:0]         page_bytes,
  input wire logic               op_busy,
  input wire logic               op_done,
  input wire logic [PAGE_AW-1:0] op_first_page,
  input wire logic [12:0]        op_span,
  input wire logic               standby
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || !reset_n_pin);

  chk_oe_at_end: assert property (frame_end |-> !so_oe)
    else $error("output enabled at frame end");
  chk_rx_when_sel: assert property (rx_valid |-> selected)
    else $error("byte taken while deselected");
  chk_start_drives: assert property (frame_start |-> so_oe && selected)
    else $error("frame start without drive");
  chk_oe_cause: assert property ($rose(so_oe) |-> frame_start)
    else $error("output enabled outside frame start");
  chk_busy_standby: assert property (op_busy || op_done |-> !standby)
    else $error("standby during operation");
  chk_opcode_index: assert property (rx_valid |-> rx_is_opcode == (rx_index == 16'h0))
    else $error("opcode flag and index disagree");
  chk_done_follows: assert property ($fell(op_busy) |-> op_done)
    else $error("busy fell without done");
  chk_done_pulse: assert property (op_done |=> !op_done && !op_busy)
    else $error("done longer than one cycle");
  chk_span_align: assert property (op_busy |-> (op_first_page & (op_span[11:0] - 12'h1)) == 12'h0)
    else $error("first page not aligned to span");
  chk_page_size: assert property (!$past(rst) && $stable(page_bin)
    |-> page_bytes == (page_bin ? 9'h100 : 9'h108))
    else $error("page size wrong");
  chk_pin_abort: assert property (disable iff (rst) !reset_n_pin [*4] |-> !op_busy && !so_oe)
    else $error("pin reset did not abort");

  cov_opcode: cover property (rx_valid && rx_is_opcode);
  cov_done: cover property (op_done);
  cov_end: cover property (frame_end);
endmodule

bind sfe_front_end sfe_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .reset_n_pin(reset_n_pin), .page_bin(page_bin), .so_oe(so_oe), .rx_valid(rx_valid),
  .rx_is_opcode(rx_is_opcode), .rx_index(rx_index), .frame_start(frame_start),
  .frame_end(frame_end), .selected(selected), .page_bytes(page_bytes), .op_busy(op_busy),
  .op_done(op_done), .op_first_page(op_first_page), .op_span(op_span), .standby(standby));
`default_nettype wire

/* File: bench/sfe_host_model.sv */
// Serial host model driving chip select, clock and data in modes 0 and 3.
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
  // Clock and serial pins.
  input  wire logic clk_sys,
  input  wire logic so_line,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic cpol;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    cpol = 1'b0;
  end
  // Half a serial period of 200 ns keeps the clock far below its ceiling.
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic sel(input logic m3);
    cpol = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    sck = cpol;
    cs_n = 1'b1;
    half();
  endtask
  task automatic bits(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si = d[i];
      half();
      sck = 1'b1;
      q[i] = so_line;
      half();
    end
  endtask
  // Toggles clock and data with the device deselected.
  task automatic noise();
    for (int i = 0; i < 16; i++)
    begin
      sck = ~sck;
      si = ~si;
      half();
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/test_sfe_front_end.sv */
// Self-checking bench of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module test_sfe_front_end
  import sfe_pkg::*;
;
  // Short program and erase times; sector and chip erase keep their long
  // defaults and are cut short by the reset pin instead.
  localparam int T_PROG  = 500;
  localparam int T_PG_ER = 600;
  localparam int T_BK_ER = 700;
  logic        clk_sys, rst, reset_n_pin, so_o, so_oe, rx_valid, rx_is_opcode;
  logic        frame_start, frame_end, selected, tx_take, buf_rd_sel, page_bin;
  logic        op_busy, op_done, standby, cs_n_pin, sck_pin, si_pin, so_line;
  logic [7:0]  rx_byte, tx_byte, buf_rdata, q0, q1;
  logic [15:0] rx_index;
  logic [8:0]  buf_rd_addr, page_bytes;
  logic [11:0] op_first_page;
  logic [12:0] op_span;
  sfe_buf_wr_t buf_wr;
  sfe_op_req_t op_req;
  logic [16:0] rxq[$];
  int          fail_count, compares;

  assign so_line = so_oe ? so_o : ~so_o;
  sfe_front_end #(.T_PROG_NS(T_PROG), .T_PAGE_ER_NS(T_PG_ER), .T_BLK_ER_NS(T_BK_ER))
    DUT (.clk_sys(clk_sys), .rst(rst),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .reset_n_pin(reset_n_pin),
    .so_o(so_o), .so_oe(so_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_is_opcode(rx_is_opcode), .rx_index(rx_index), .frame_start(frame_start),
    .frame_end(frame_end), .selected(selected), .tx_byte(tx_byte), .tx_take(tx_take),
    .buf_wr(buf_wr), .buf_rd_sel(buf_rd_sel), .buf_rd_addr(buf_rd_addr),
    .buf_rdata(buf_rdata), .page_bin(page_bin), .page_bytes(page_bytes),
    .op_req(op_req), .op_busy(op_busy), .op_done(op_done),
    .op_first_page(op_first_page), .op_span(op_span), .standby(standby));
  sfe_host_model h (.clk_sys(clk_sys), .so_line(so_line), .cs_n(cs_n_pin),
    .sck(sck_pin), .si(si_pin));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
    if (rx_valid === 1'b1) rxq.push_back({rx_is_opcode, rx_index[7:0], rx_byte});
  always @(negedge clk_sys)
    if (tx_take === 1'b1) tx_byte <= tx_byte + 8'h01;

  task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_frame(input logic m3);
    rxq.delete();
    tx_byte = 8'hc3;
    h.sel(m3);
    chk("so_oe", 17'h1, {16'h0, so_oe});
    h.bits(8'ha5, 8, q0);
    h.bits(8'h3c, 8, q1);
    h.desel();
    chk("rx0", {1'b1, 8'h00, 8'ha5}, rxq[0]);
    chk("rx1", {1'b0, 8'h01, 8'h3c}, rxq[1]);
    chk("so", {1'b0, 8'hc3, 8'hc4}, {1'b0, q0, q1});
  endtask
  task automatic t_idle_part();
    rxq.delete();
    h.noise();
    chk("idle", 17'h10000, {standby, so_oe, 15'(rxq.size())});
    h.sel(1'b0);
    h.bits(8'hff, 4, q0);
    h.desel();
    h.sel(1'b0);
    h.bits(8'h81, 8, q0);
    h.desel();
    chk("count", 17'h1, 17'(rxq.size()));
    chk("realign", {1'b1, 8'h00, 8'h81}, rxq[0]);
  endtask
  task automatic t_ops();
    logic [12:0] sp[5];
    int          cyc[3];
    int          n;
    sp = '{SPAN_PAGE, SPAN_PAGE, SPAN_BLOCK, SPAN_SECTOR, SPAN_CHIP};
    cyc = '{T_PROG / CLK_PERIOD_NS, T_PG_ER / CLK_PERIOD_NS, T_BK_ER / CLK_PERIOD_NS};
    for (int k = 0; k < 5; k++)
    begin
      op_req = '{1'b1, sfe_op_kind_t'(k), 12'hfff};
      @(negedge clk_sys);
      op_req.start = 1'b0;
      n = 1;
      chk("standby", 17'h0, {16'h0, standby});
      chk("span", {4'h0, sp[k]}, {4'h0, op_span});
      chk("first", {5'h0, 12'hfff & ~(sp[k][11:0] - 12'h1)}, {5'h0, op_first_page});
      if (k < 3)
      begin
        while (op_done !== 1'b1 && n < 50)
        begin
          @(negedge clk_sys);
          n++;
        end
        chk("cycles", 17'(cyc[k] + 1), 17'(n));
        repeat (2) @(negedge clk_sys);
        chk("standby", 17'h1, {16'h0, standby});
      end
      else
      begin
        chk("busy", 17'h1, {16'h0, op_busy});
        reset_n_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("abort", 17'h0, {16'h0, op_busy});
        reset_n_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
      end
    end
  endtask
  task automatic bw(input logic s, input logic [8:0] a, input logic [7:0] d);
    buf_wr = '{1'b1, s, a, d};
    @(negedge clk_sys);
    buf_wr.we = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic br(input logic s, input logic [8:0] a, input logic [7:0] e);
    buf_rd_sel = s;
    buf_rd_addr = a;
    @(negedge clk_sys);
    chk("buf", {9'h0, e}, {9'h0, buf_rdata});
  endtask
  task automatic t_rst_buf();
    op_req = '{1'b1, OPK_CHIP_ER, 12'h0};
    @(negedge clk_sys);
    op_req.start = 1'b0;
    reset_n_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("abort", 17'h0, {15'h0, op_busy, so_oe});
    reset_n_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    op_req = '{1'b1, OPK_PROGRAM, 12'h0};
    @(negedge clk_sys);
    op_req.start = 1'b0;
    bw(1'b1, 9'h107, 8'h5a);
    bw(1'b1, 9'h108, 8'ha5);
    bw(1'b0, 9'h107, 8'h3c);
    chk("busy", 17'h1, {16'h0, op_busy});
    br(1'b1, 9'h107, 8'h5a);
    br(1'b0, 9'h107, 8'h3c);
    br(1'b1, 9'h108, 8'h00);
    chk("page", 17'h108, {8'h0, page_bytes});
    page_bin = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("page", 17'h100, {8'h0, page_bytes});
    br(1'b1, 9'h100, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    reset_n_pin = 1'b1;
    page_bin = 1'b0;
    tx_byte = 8'hc3;
    buf_wr = '0;
    buf_rd_sel = 1'b0;
    buf_rd_addr = 9'h0;
    op_req = '0;
    fail_count = 0;
    compares = 0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_frame(1'b0);
    t_frame(1'b1);
    t_idle_part();
    t_ops();
    t_rst_buf();
    print_verdict();
  end
  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
